/* File: src/hubcl_loader.sv */
// hub configuration loader: serial EEPROM fetch and descriptor field derivation
module hubcl_loader
   import hubcl_pkg::*;
#(
   // built-in identifiers, values arbitrary
   parameter logic [15:0] BUILTIN_VID = 16'h1A2B,
   parameter logic [15:0] BUILTIN_PID = 16'h3C4D,
   parameter logic [15:0] BUILTIN_DID = 16'h0100
) (
   // core clock and reset
   input  wire logic      core_clk,
   input  wire logic      rst_n,
   // link clock for the serial engine
   input  wire logic      link_clk,
   // serial EEPROM pins
   output logic           spi_sck,
   output logic           spi_cs_n,
   output logic           spi_mosi,
   input  wire logic      spi_miso,
   // hub descriptor request check
   input  wire logic      desc_req,
   input  wire logic [7:0] desc_type,
   output logic           desc_ack,
   output logic           desc_stall,
   // loaded configuration
   output logic           config_ready,
   output hubcl_kind_t    image_kind,
   output hubcl_ids_t     ids_o,
   output hubcl_cfg_t     cfg_o,
   output hubcl_hub_desc_t desc_o
);

   // ********************
   // helper functions
   // ********************
   function automatic logic [2:0] count_ports(input logic [3:0] m);
      count_ports = {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]} + {2'b00, m[3]};
   endfunction : count_ports

   function automatic logic [15:0] build_char(input hubcl_cfg_t c);
      logic [15:0] v;
      v = HUB_CHAR_DEF;
      if (c.shared_power_switching) begin
         v[HC_PWR_LO +: 2] = 2'b00; // R20
         v[HC_OC_LO +: 2]  = 2'b00; // R20
      end
      if (c.indicators_off) begin
         v[HC_IND] = 1'b0; // R15
      end
      build_char = v;
   endfunction : build_char

   function automatic logic [3:0] byte_slot(input logic [7:0] bit_no);
      logic [7:0] off;
      off = bit_no - 8'(CMD_BITS);
      byte_slot = off[6:3];
   endfunction : byte_slot

   function automatic hubcl_cfg_t default_cfg();
      hubcl_cfg_t c;
      c.enabled_port_oc_filter_ms  = DEF_OC[7:4];
      c.disabled_port_oc_filter_ms = DEF_OC[3:0];
      c.usable_port_mask           = DEF_PORTS[7:4];
      c.removable_port_mask        = DEF_REMOVABLE; // R18
      c.upstream_current_budget    = DEF_MAXPWR;
      c.controller_current_ma      = DEF_CTRL; // R19
      c.port_power_good_delay      = DEF_PWRON; // R19
      c.accept_zero_desc_type      = DEF_OPTS[OPT_ZERO_TYPE];
      c.force_full_speed           = DEF_OPTS[OPT_FS_ONLY];
      c.indicators_off             = DEF_OPTS[OPT_NO_IND];
      c.shared_power_switching     = DEF_OPTS[OPT_GANGED];
      c.one_translator_only        = DEF_OPTS[OPT_SINGLE_TT];
      c.suppress_early_frame_eop   = DEF_OPTS[OPT_NO_EOP];
      default_cfg = c;
   endfunction : default_cfg

   // ********************
   // declarations
   // ********************
   hubcl_core_st_t  core_st_ff;
   logic            req_tgl_ff;
   logic            done_s;
   logic            done_seen_ff;
   hubcl_ids_t      ids_ff;
   hubcl_cfg_t      cfg_ff;
   hubcl_kind_t     kind_ff;
   hubcl_hub_desc_t desc_ff;
   logic            ready_ff;

   logic            link_rst_n;
   logic            req_s;
   logic            miso_s;
   hubcl_link_st_t  link_st_ff;
   logic            req_seen_ff;
   logic [1:0]      phase_ff;
   logic [7:0]      bit_cnt_ff;
   logic [23:0]     cmd_sr_ff;
   logic [7:0]      rx_sr_ff;
   logic [7:0]      img_ff [IMG_BYTES];
   logic            sck_ff;
   logic            mosi_ff;
   logic            cs_n_ff;
   logic            done_tgl_ff;
   logic [7:0]      nxt_rx;

   // ********************
   // crossings
   // ********************
   // link reset asserts at once, releases on link clock
   hubcl_sync2 u_link_rst (
      .clk   (link_clk),
      .rst_n (rst_n),
      .d     (1'b1),
      .q     (link_rst_n)
   );

   hubcl_sync2 u_req_sync (
      .clk   (link_clk),
      .rst_n (link_rst_n),
      .d     (req_tgl_ff),
      .q     (req_s)
   );

   hubcl_sync2 u_miso_sync (
      .clk   (link_clk),
      .rst_n (link_rst_n),
      .d     (spi_miso),
      .q     (miso_s)
   );

   hubcl_sync2 u_done_sync (
      .clk   (core_clk),
      .rst_n (rst_n),
      .d     (done_tgl_ff),
      .q     (done_s)
   );

   // ********************
   // core sequencer
   // ********************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_st_ff   <= C_KICK;
         req_tgl_ff   <= 1'b0;
         done_seen_ff <= 1'b0;
      end else begin
         case (core_st_ff)
            C_KICK: begin
               req_tgl_ff <= ~req_tgl_ff; // R23
               core_st_ff <= C_WAIT;
            end
            C_WAIT: begin
               if (done_s != done_seen_ff) begin
                  done_seen_ff <= done_s;
                  core_st_ff   <= C_DECODE;
               end
            end
            C_DECODE: begin
               core_st_ff <= C_PUBLISH;
            end
            C_PUBLISH: begin
               core_st_ff <= C_READY;
            end
            C_READY: begin
               core_st_ff <= C_READY;
            end
            default: begin
               core_st_ff <= C_KICK;
            end
         endcase
      end
   end

   // ****************************************
   // image decode
   // ****************************************
   // image array is static while the link idles after its done toggle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ids_ff  <= '{vendor_id: 16'h0000, product_id: 16'h0000, device_release_id: 16'h0000};
         cfg_ff  <= default_cfg();
         kind_ff <= IMG_BUILTIN;
      end else if (core_st_ff == C_KICK) begin
         ids_ff.vendor_id         <= BUILTIN_VID; // R24
         ids_ff.product_id        <= BUILTIN_PID; // R24
         ids_ff.device_release_id <= BUILTIN_DID; // R24
         cfg_ff                   <= default_cfg(); // R24
         kind_ff                  <= IMG_BUILTIN;
      end else if (core_st_ff == C_DECODE) begin
         if (img_ff[BYTE_MARK] == MARK_ID_ONLY || img_ff[BYTE_MARK] == MARK_FULL) begin
            ids_ff.vendor_id         <= {img_ff[BYTE_VID_HI], img_ff[BYTE_VID_LO]}; // R3
            ids_ff.product_id        <= {img_ff[BYTE_PID_HI], img_ff[BYTE_PID_LO]}; // R3
            ids_ff.device_release_id <= {img_ff[BYTE_DID_HI], img_ff[BYTE_DID_LO]}; // R3
            kind_ff                  <= IMG_ID_ONLY;
         end
         if (img_ff[BYTE_MARK] == MARK_FULL) begin
            kind_ff                             <= IMG_FULL; // R4
            cfg_ff.enabled_port_oc_filter_ms    <= img_ff[BYTE_OC][7:4]; // R5
            cfg_ff.disabled_port_oc_filter_ms   <= img_ff[BYTE_OC][3:0]; // R5
            cfg_ff.usable_port_mask             <= img_ff[BYTE_PORTS][7:4]; // R6
            cfg_ff.removable_port_mask          <= img_ff[BYTE_PORTS][3:0]; // R7
            cfg_ff.upstream_current_budget      <= img_ff[BYTE_MAXPWR]; // R8
            cfg_ff.controller_current_ma        <= img_ff[BYTE_CTRL]; // R9
            cfg_ff.port_power_good_delay        <= img_ff[BYTE_PWRON]; // R10
            cfg_ff.accept_zero_desc_type        <= img_ff[BYTE_OPTS][OPT_ZERO_TYPE]; // R11
            cfg_ff.force_full_speed             <= img_ff[BYTE_OPTS][OPT_FS_ONLY]; // R14
            cfg_ff.indicators_off               <= img_ff[BYTE_OPTS][OPT_NO_IND]; // R15
            cfg_ff.shared_power_switching       <= img_ff[BYTE_OPTS][OPT_GANGED]; // R20
            cfg_ff.one_translator_only          <= img_ff[BYTE_OPTS][OPT_SINGLE_TT]; // R21
            cfg_ff.suppress_early_frame_eop     <= img_ff[BYTE_OPTS][OPT_NO_EOP]; // R22
            // R13
         end
      end
   end

   // ****************************************
   // hub descriptor fields
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         desc_ff <= '{nbr_ports: 3'd0, hub_char: 16'h0000, pwr_on_good: 8'h00,
                      ctrl_current: 8'h00, device_removable: 8'h00, pwr_ctrl_mask: 8'h00};
      end else begin
         desc_ff.nbr_ports        <= count_ports(cfg_ff.usable_port_mask); // R6
         desc_ff.hub_char         <= build_char(cfg_ff); // R15
         desc_ff.pwr_on_good      <= cfg_ff.port_power_good_delay; // R10
         desc_ff.ctrl_current     <= cfg_ff.controller_current_ma; // R9
         // bit 0 of the removable byte is reserved, ports start at bit 1
         desc_ff.device_removable <= {3'b000, cfg_ff.removable_port_mask, 1'b0}; // R7
         desc_ff.pwr_ctrl_mask    <= PWR_CTRL_MASK; // R17
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_ff <= 1'b0;
      end else begin
         ready_ff <= (core_st_ff == C_PUBLISH) || ready_ff; // R23
      end
   end

   // ****************************************
   // descriptor request check
   // ****************************************
   // before the image is in, requests get neither answer and wait
   always_comb begin
      desc_ack   = 1'b0;
      desc_stall = 1'b0;
      if (desc_req && ready_ff) begin
         if (desc_type == DESC_TYPE_HUB) begin
            desc_ack = 1'b1;
         end else if (desc_type == DESC_TYPE_ZERO && cfg_ff.accept_zero_desc_type) begin
            desc_ack = 1'b1; // R11
         end else begin
            desc_stall = 1'b1; // R12
         end
      end
   end

   assign config_ready = ready_ff;
   assign image_kind   = kind_ff;
   assign ids_o        = ids_ff;
   assign cfg_o        = cfg_ff;
   assign desc_o       = desc_ff;

   // ****************************************
   // serial engine on link clock
   // ****************************************
   // sck is link clock over four; miso sampled late in the high half
   // so the two-flop delay still lands inside the data valid window
   assign nxt_rx = {rx_sr_ff[6:0], miso_s};

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_st_ff  <= L_IDLE;
         req_seen_ff <= 1'b0;
         phase_ff    <= 2'd0;
         bit_cnt_ff  <= 8'd0;
         cmd_sr_ff   <= 24'h00_0000;
         sck_ff      <= 1'b0;
         mosi_ff     <= 1'b0;
         cs_n_ff     <= 1'b1;
         done_tgl_ff <= 1'b0;
      end else begin
         case (link_st_ff)
            L_IDLE: begin
               sck_ff <= 1'b0;
               if (req_s != req_seen_ff) begin
                  req_seen_ff <= req_s;
                  cs_n_ff     <= 1'b0;
                  cmd_sr_ff   <= {SPI_READ_CMD, SPI_START_ADDR}; // R2
                  phase_ff    <= 2'd0;
                  bit_cnt_ff  <= 8'd0;
                  link_st_ff  <= L_SHIFT;
               end
            end
            L_SHIFT: begin
               phase_ff <= phase_ff + 2'd1;
               case (phase_ff)
                  2'd0: begin
                     sck_ff  <= 1'b0;
                     mosi_ff <= cmd_sr_ff[23]; // R2
                  end
                  2'd2: begin
                     sck_ff <= 1'b1;
                  end
                  2'd3: begin
                     cmd_sr_ff  <= {cmd_sr_ff[22:0], 1'b0};
                     bit_cnt_ff <= bit_cnt_ff + 8'd1;
                     if (bit_cnt_ff == 8'(TOTAL_BITS - 1)) begin
                        link_st_ff <= L_END;
                     end
                  end
                  default: begin
                     sck_ff <= 1'b0;
                  end
               endcase
            end
            L_END: begin
               sck_ff      <= 1'b0;
               mosi_ff     <= 1'b0;
               cs_n_ff     <= 1'b1;
               done_tgl_ff <= ~done_tgl_ff;
               link_st_ff  <= L_IDLE;
            end
            default: begin
               link_st_ff <= L_IDLE;
            end
         endcase
      end
   end

   // receive shifter and image store
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_sr_ff <= 8'h00;
      end else if (link_st_ff == L_SHIFT && phase_ff == 2'd3
                   && bit_cnt_ff >= 8'(CMD_BITS)) begin
         rx_sr_ff <= nxt_rx;
      end
   end

   // no reset on the image array; it is read only after a full fetch
   always_ff @(posedge link_clk) begin
      if (link_st_ff == L_SHIFT && phase_ff == 2'd3 && bit_cnt_ff >= 8'(CMD_BITS)
          && bit_cnt_ff[2:0] == 3'd7) begin
         img_ff[byte_slot(bit_cnt_ff)] <= nxt_rx; // R4
      end
   end

   assign spi_sck  = sck_ff;
   assign spi_cs_n = cs_n_ff;
   assign spi_mosi = mosi_ff;

endmodule : hubcl_loader

/* File: src/hubcl_pkg.sv */
// constants and carrier types of the hub configuration loader
//
// How it works
// R1 - an SPI EEPROM replaces built-in identifiers
// R2 - two address bytes and one plain read command only
// R3 - marker 0xD0 means identity-only image, ids low byte first
// R4 - marker 0xD2 means full image of bytes 0 to 12
// R5 - byte 7 gives overcurrent filter ms, enabled high nibble, default 0x88
// R6 - byte 8 high nibble is usable port mask, port count derived
// R7 - byte 8 low nibble marks removable ports in descriptor
// R8 - byte 9 is maximum power in 2 mA units, default 0x32
// R9 - byte 10 is controller current in mA, default 0x64
// R10 - byte 11 is power-on-to-good time in 2 ms units, default 0x32
// R11 - byte 12 bit 7 set lets descriptor type 0x00 be accepted
// R12 - byte 12 bit 7 clear stalls hub descriptor types other than 0x29
// R13 - byte 12 bit 6 is ignored
// R14 - byte 12 bit 5 forces full-speed only operation
// R15 - byte 12 bit 4 turns indicators off and clears characteristics bit 7
// R16 - image writer keeps byte 12 bit 3 zero
// R17 - port power control mask reported as 0xFF
// R18 - device-removable byte is 0x00 by default
// R19 - default power-good time 0x32 and controller current 0x64
// R20 - byte 12 bit 2 selects ganged power switching, characteristics follow
// R21 - byte 12 bit 1 restricts hub to a single translator
// R22 - byte 12 bit 0 suppresses end-of-packet at first frame end point
// R23 - read image from address zero after reset before enumeration
// R24 - unknown marker or absent EEPROM keeps built-in values
package hubcl_pkg;

   // ********************
   // image layout
   // ********************
   localparam int          IMG_BYTES     = 13;
   localparam logic [7:0]  MARK_ID_ONLY  = 8'hD0;
   localparam logic [7:0]  MARK_FULL     = 8'hD2;
   localparam int          BYTE_MARK     = 0;
   localparam int          BYTE_VID_LO   = 1;
   localparam int          BYTE_VID_HI   = 2;
   localparam int          BYTE_PID_LO   = 3;
   localparam int          BYTE_PID_HI   = 4;
   localparam int          BYTE_DID_LO   = 5;
   localparam int          BYTE_DID_HI   = 6;
   localparam int          BYTE_OC       = 7;
   localparam int          BYTE_PORTS    = 8;
   localparam int          BYTE_MAXPWR   = 9;
   localparam int          BYTE_CTRL     = 10;
   localparam int          BYTE_PWRON    = 11;
   localparam int          BYTE_OPTS     = 12;
   localparam int          OPT_ZERO_TYPE = 7;
   localparam int          OPT_FS_ONLY   = 5;
   localparam int          OPT_NO_IND    = 4;
   localparam int          OPT_GANGED    = 2;
   localparam int          OPT_SINGLE_TT = 1;
   localparam int          OPT_NO_EOP    = 0;

   // ********************
   // defaults and descriptor constants
   // ********************
   localparam logic [7:0]  DEF_OC        = 8'h88;
   localparam logic [7:0]  DEF_PORTS     = 8'hFF;
   localparam logic [7:0]  DEF_MAXPWR    = 8'h32;
   localparam logic [7:0]  DEF_CTRL      = 8'h64;
   localparam logic [7:0]  DEF_PWRON     = 8'h32;
   localparam logic [7:0]  DEF_OPTS      = 8'h00;
   localparam logic [3:0]  DEF_REMOVABLE = 4'h0;
   localparam logic [7:0]  DESC_TYPE_HUB = 8'h29;
   localparam logic [7:0]  DESC_TYPE_ZERO = 8'h00;
   localparam logic [7:0]  PWR_CTRL_MASK = 8'hFF;
   localparam logic [15:0] HUB_CHAR_DEF  = 16'h0089;
   localparam int          HC_PWR_LO     = 0;
   localparam int          HC_OC_LO      = 3;
   localparam int          HC_IND        = 7;

   // ********************
   // serial link
   // ********************
   localparam logic [7:0]  SPI_READ_CMD  = 8'h03;
   localparam logic [15:0] SPI_START_ADDR = 16'h0000;
   localparam int          CMD_BITS      = 24;
   localparam int          TOTAL_BITS    = CMD_BITS + IMG_BYTES * 8;

   // ********************
   // carrier types
   // ********************
   typedef struct packed {
      logic [15:0] vendor_id;
      logic [15:0] product_id;
      logic [15:0] device_release_id;
   } hubcl_ids_t;

   typedef struct packed {
      logic [3:0] enabled_port_oc_filter_ms;
      logic [3:0] disabled_port_oc_filter_ms;
      logic [3:0] usable_port_mask;
      logic [3:0] removable_port_mask;
      logic [7:0] upstream_current_budget;
      logic [7:0] controller_current_ma;
      logic [7:0] port_power_good_delay;
      logic       accept_zero_desc_type;
      logic       force_full_speed;
      logic       indicators_off;
      logic       shared_power_switching;
      logic       one_translator_only;
      logic       suppress_early_frame_eop;
   } hubcl_cfg_t;

   typedef struct packed {
      logic [2:0]  nbr_ports;
      logic [15:0] hub_char;
      logic [7:0]  pwr_on_good;
      logic [7:0]  ctrl_current;
      logic [7:0]  device_removable;
      logic [7:0]  pwr_ctrl_mask;
   } hubcl_hub_desc_t;

   typedef enum logic [1:0] {
      IMG_BUILTIN = 2'b00,
      IMG_ID_ONLY = 2'b01,
      IMG_FULL    = 2'b10
   } hubcl_kind_t;

   typedef enum logic [2:0] {
      C_KICK    = 3'b000,
      C_WAIT    = 3'b001,
      C_DECODE  = 3'b010,
      C_PUBLISH = 3'b011,
      C_READY   = 3'b100
   } hubcl_core_st_t;

   typedef enum logic [1:0] {
      L_IDLE  = 2'b00,
      L_SHIFT = 2'b01,
      L_END   = 2'b10
   } hubcl_link_st_t;

endpackage : hubcl_pkg

/* File: src/hubcl_sync2.sv */
// two-stage level synchroniser
module hubcl_sync2 (
   // clock and reset of the receiving domain
   input  wire logic clk,
   input  wire logic rst_n,
   // level in and synchronised level out
   input  wire logic d,
   output logic      q
);
   logic stage1_ff;
   logic stage2_ff;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end else begin
         stage1_ff <= d;
         stage2_ff <= stage1_ff;
      end
   end

   assign q = stage2_ff;

endmodule : hubcl_sync2

/* File: tb/hubcl_eeprom_model.sv */
// behavioural serial EEPROM holding one configuration image
module hubcl_eeprom_model (
   // serial pins
   input  wire logic         spi_sck,
   input  wire logic         spi_cs_n,
   input  wire logic         spi_mosi,
   output logic             spi_miso,
   // image and presence
   input  wire logic [103:0] image,
   input  wire logic         present,
   // last command and address seen
   output logic [23:0]       cmd_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   int   bit_cnt = 0;
   logic out_ff = 1'b1;
   // mode 0, command then two address bytes
   always @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n)
         bit_cnt <= 0;
      else begin
         if (bit_cnt < 24)
            cmd_seen <= {cmd_seen[22:0], spi_mosi};
         bit_cnt <= bit_cnt + 1;
      end
   end
   // data moves on the falling edge with a real valid delay
   always @(negedge spi_sck) begin
      if (!spi_cs_n && bit_cnt >= 24 && bit_cnt < 128)
         out_ff <= #20 image[127 - bit_cnt];
   end
   // pulled up when absent, deselected or in the command phase
   assign spi_miso = (present && !spi_cs_n && bit_cnt >= 24) ? out_ff : 1'b1;
endmodule : hubcl_eeprom_model

/* File: tb/hubcl_loader_properties.sv */
// concurrent checks on the hub configuration loader ports
module hubcl_loader_properties
   import hubcl_pkg::*;
(
   // clock and reset
   input wire logic            core_clk,
   input wire logic            rst_n,
   // serial select and descriptor check
   input wire logic            spi_cs_n,
   input wire logic            desc_req,
   input wire logic [7:0]      desc_type,
   input wire logic            desc_ack,
   input wire logic            desc_stall,
   // loaded values
   input wire logic            config_ready,
   input wire hubcl_kind_t     image_kind,
   input wire hubcl_ids_t      ids_o,
   input wire hubcl_cfg_t      cfg_o,
   input wire hubcl_hub_desc_t desc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // properties
   // ********************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_req;
      desc_req && config_ready;
   endsequence
   sequence s_ready_rise;
      !config_ready ##1 config_ready;
   endsequence
   hub_type_ack_a: assert property (s_req ##0 desc_type == DESC_TYPE_HUB |->
      desc_ack && !desc_stall) else $error("hub type not acked");
   zero_type_a: assert property (s_req ##0 desc_type == DESC_TYPE_ZERO |->
      desc_ack == cfg_o.accept_zero_desc_type && desc_stall == !desc_ack)
      else $error("zero type answer wrong");
   other_type_a: assert property (s_req ##0 (desc_type != DESC_TYPE_HUB &&
      desc_type != DESC_TYPE_ZERO) |-> desc_stall && !desc_ack) else $error("no stall");
   busy_quiet_a: assert property (!config_ready |-> !desc_ack && !desc_stall)
      else $error("answer before load done");
   fetch_done_a: assert property (s_ready_rise |-> spi_cs_n)
      else $error("ready while fetch runs");
   ready_hold_a: assert property (config_ready |=> config_ready && $stable(ids_o)
      && $stable(desc_o)) else $error("loaded values moved");
   port_count_a: assert property (config_ready |->
      desc_o.nbr_ports == $countones(cfg_o.usable_port_mask)) else $error("port count");
   removable_map_a: assert property (config_ready |->
      desc_o.device_removable == {3'h0, cfg_o.removable_port_mask, 1'h0})
      else $error("removable field");
   desc_copy_a: assert property (config_ready |->
      desc_o.pwr_ctrl_mask == PWR_CTRL_MASK && desc_o.pwr_on_good == cfg_o.port_power_good_delay
      && desc_o.ctrl_current == cfg_o.controller_current_ma) else $error("desc copy");
   indicator_bit_a: assert property (config_ready |->
      desc_o.hub_char[HC_IND] == !cfg_o.indicators_off) else $error("indicator bit");
   ganged_bits_a: assert property (config_ready |-> cfg_o.shared_power_switching ==
      (desc_o.hub_char[1:0] == 2'h0 && desc_o.hub_char[4:3] == 2'h0)) else $error("ganged");
   builtin_def_a: assert property (config_ready && image_kind != IMG_FULL |->
      cfg_o.upstream_current_budget == DEF_MAXPWR && cfg_o.usable_port_mask == 4'hF)
      else $error("defaults lost");
endmodule : hubcl_loader_properties

bind hubcl_loader hubcl_loader_properties hubcl_loader_properties_i (.core_clk, .rst_n,
   .spi_cs_n, .desc_req, .desc_type, .desc_ack, .desc_stall, .config_ready,
   .image_kind, .ids_o, .cfg_o, .desc_o);

/* File: tb/testbench.sv */
// self-checking bench of the hub configuration loader
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
   $display("FAIL %s exp %h got %h", nm, e, s); end end
module testbench
   import hubcl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] BV = 16'h5E01; // arbitrary
   localparam logic [15:0] BP = 16'h6F02; // arbitrary
   localparam logic [15:0] BD = 16'h0003; // arbitrary
   logic core_clk, link_clk, rst_n, desc_req, desc_ack, desc_stall, config_ready;
   logic spi_sck, spi_cs_n, spi_mosi, spi_miso, present;
   logic [7:0]      desc_type;
   logic [103:0]    image;
   logic [23:0]     cmd_seen;
   hubcl_kind_t     image_kind;
   hubcl_ids_t      ids_o;
   hubcl_cfg_t      cfg_o;
   hubcl_hub_desc_t desc_o;
   int n_mismatch = 0;
   int comparisons = 0;
   hubcl_loader #(.BUILTIN_VID(BV), .BUILTIN_PID(BP), .BUILTIN_DID(BD)) hubcl_loader_i (
      .core_clk, .rst_n, .link_clk, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .desc_req,
      .desc_type, .desc_ack, .desc_stall, .config_ready, .image_kind, .ids_o, .cfg_o,
      .desc_o);
   hubcl_eeprom_model hubcl_eeprom_model_i (.spi_sck, .spi_cs_n, .spi_mosi, .spi_miso,
      .image, .present, .cmd_seen);
   // ********************
   // clocks and run control
   // ********************
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #37;
      forever #80 link_clk = ~link_clk;
   end
   initial begin
      #600us;
      n_mismatch++;
      summarize();
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   // reset, fetch, held request gets no answer while busy
   task automatic load(input logic [103:0] im, input logic p);
      image = im;
      present = p;
      @(posedge core_clk);
      rst_n <= 1'b0;
      desc_req <= 1'b1;
      desc_type <= DESC_TYPE_HUB;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (100) @(posedge core_clk);
      @(negedge core_clk);
      `CHK("busy", 2'h0, {desc_ack, desc_stall})
      for (int i = 0; i < 15000 && config_ready !== 1'b1; i++) @(negedge core_clk);
      `CHK("ready", 1'b1, config_ready)
      @(posedge core_clk);
      desc_req <= 1'b0;
      if (p) `CHK("cmd", {SPI_READ_CMD, SPI_START_ADDR}, cmd_seen)
   endtask : load
   task automatic req(input logic [7:0] t, input logic [1:0] e);
      @(posedge core_clk);
      desc_req <= 1'b1;
      desc_type <= t;
      @(negedge core_clk);
      `CHK("ack_stall", e, {desc_ack, desc_stall})
      @(posedge core_clk);
      desc_req <= 1'b0;
   endtask : req
   // built-in configuration
   task automatic chk_def();
      `CHK("oc", 8'h88, cfg_o[45:38])
      `CHK("ports", 3'h4, desc_o.nbr_ports)
      `CHK("remov", 8'h00, desc_o.device_removable)
      `CHK("maxpwr", 8'h32, cfg_o.upstream_current_budget)
      `CHK("ctrl", 8'h64, desc_o.ctrl_current)
      `CHK("pwron", 8'h32, desc_o.pwr_on_good)
      `CHK("char", 16'h0089, desc_o.hub_char)
      `CHK("mask", 8'hFF, desc_o.pwr_ctrl_mask)
   endtask : chk_def
   // full image, zero type accepted, ports 1 and 4 usable
   task automatic t_full();
      load({MARK_FULL, 48'h3412_7856_BC9A, 48'h5A96_7D40_19A1}, 1'b1);
      `CHK("kind", IMG_FULL, image_kind)
      `CHK("ids", 48'h1234_5678_9ABC, ids_o)
      `CHK("oc", 8'h5A, cfg_o[45:38])
      `CHK("ports", 3'h2, desc_o.nbr_ports)
      `CHK("remov", 8'h0C, desc_o.device_removable)
      `CHK("maxpwr", 8'h7D, cfg_o.upstream_current_budget)
      `CHK("ctrl", 8'h40, desc_o.ctrl_current)
      `CHK("pwron", 8'h19, desc_o.pwr_on_good)
      `CHK("opts", 6'h31, cfg_o[5:0])
      `CHK("char", 16'h0089, desc_o.hub_char)
      req(DESC_TYPE_HUB, 2'h2);
      req(DESC_TYPE_ZERO, 2'h2);
      req(8'h06, 2'h1);
   endtask : t_full
   // unused bit set, reserved bit kept zero, ganged, no indicators
   task automatic t_gang();
      load({MARK_FULL, 48'h0100_FFFF_0000, 48'h0FF0_01FF_0056}, 1'b1);
      `CHK("ids", 48'h0001_FFFF_0000, ids_o)
      `CHK("oc", 8'h0F, cfg_o[45:38])
      `CHK("ports", 3'h4, desc_o.nbr_ports)
      `CHK("remov", 8'h00, desc_o.device_removable)
      `CHK("ctrl", 8'hFF, desc_o.ctrl_current)
      `CHK("pwron", 8'h00, desc_o.pwr_on_good)
      `CHK("opts", 6'h0E, cfg_o[5:0])
      `CHK("char", 16'h0000, desc_o.hub_char)
      req(DESC_TYPE_ZERO, 2'h1);
      req(DESC_TYPE_HUB, 2'h2);
   endtask : t_gang
   // identity image: tail bytes must be ignored
   task automatic t_idonly();
      load({MARK_ID_ONLY, 48'hCDAB_3412_0110, 48'h5A96_7D40_19A1}, 1'b1);
      `CHK("kind", IMG_ID_ONLY, image_kind)
      `CHK("ids", 48'hABCD_1234_1001, ids_o)
      `CHK("opts", 6'h00, cfg_o[5:0])
      chk_def();
      req(DESC_TYPE_ZERO, 2'h1);
   endtask : t_idonly
   // unknown marker, then no device at all
   task automatic t_fallback();
      for (int k = 0; k < 2; k++) begin
         load({8'hD1, 48'h3412_7856_BC9A, 48'h5A96_7D40_19A1}, k == 0);
         `CHK("kind", IMG_BUILTIN, image_kind)
         `CHK("ids", {BV, BP, BD}, ids_o)
         chk_def();
      end
   endtask : t_fallback
   initial begin
      rst_n = 1'b0;
      desc_req = 1'b0;
      desc_type = 8'h00;
      present = 1'b0;
      image = '0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      t_full();
      t_gang();
      t_idonly();
      t_fallback();
      summarize();
   end
endmodule : testbench
